// file: rtl/tstt_regs.svh
// Constants for the outstanding transfer table block.
// Assumes inclusion by its bare name from rtl/.
`ifndef TSTT_REGS_SVH
`define TSTT_REGS_SVH
`define TSTT_DEPTH 4
`define TSTT_IDX_W 2
`define TSTT_NCH 2
`define TSTT_NXF 2
`define TSTT_TAG_W 16
`define TSTT_RPID_W 32
`define TSTT_CH_W 16
`define TSTT_XID_W 8
`define TSTT_CNT_W 32
`define TSTT_UID_W 64
`define TSTT_LEN_W 8
`define TSTT_RC_OK 8'h00
`define TSTT_RC_FAIL 8'hFE
`define TSTT_RC_INVAL 8'hFF
`define TSTT_RPID_LO 32
`define TSTT_CTRL_FSN_MASK 8'hF0
`endif

// file: rtl/tstt_pkg.sv
// Types for the outstanding transfer table block.
// Assumes tstt_regs.svh is on the include path.
`default_nettype none
package tstt_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_QUI = 2'b01,
		ST_RESP = 2'b10
	} tstt_qstate_t;
endpackage
`default_nettype wire

// file: rtl/tstt_mem.sv
// Per-entry tag and return path storage with registered read data.
// Assumes one write port and one read port on the same clock.
`include "tstt_regs.svh"
`default_nettype none
module tstt_mem (
	input wire logic i_clk,
	input wire logic i_ce,
	input wire logic i_we,
	input wire logic [`TSTT_IDX_W-1:0] i_waddr,
	input wire logic [`TSTT_TAG_W+`TSTT_RPID_W-1:0] i_wdata,
	input wire logic [`TSTT_IDX_W-1:0] i_raddr,
	output logic [`TSTT_TAG_W+`TSTT_RPID_W-1:0] o_rdata
);
	logic [`TSTT_TAG_W+`TSTT_RPID_W-1:0] mem_r [0:`TSTT_DEPTH-1];
	always_ff @(posedge i_clk) begin
		if (i_ce && i_we) begin
			mem_r[i_waddr] <= i_wdata;
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			o_rdata <= mem_r[i_raddr];
		end
	end
endmodule
`default_nettype wire

// file: rtl/tstt_table.sv
// Contract
// - Target read or write request allocates a new outstanding table entry.
// - Entry is freed when transfer ends and completion is raised.
// - Entry tag copied from request tag and returned in completion.
// - Entry stores chosen return path; used for completion and reply check.
// - Channel added when node accepts it, removed when inactive.
// - Finished channel looks up table for tag and initiator identifier.
// - Read adds transfer id per data-ready; drops after final reply validated.
// - Return codes: 00h success, FEh failure, FFh invalid; rest reserved.
// - Byte offset is four bytes, relative to buffer base.
// - Byte count four bytes, covers only current split portion.
// - Control carries frame and reset type; sequence number field zeroed.
// - Length is one byte giving frame data field size.
// - Channel parameter is two bytes.
// - Return path identifier is four bytes.
// - In-order flag 0 stores as arrives; 1 places offset zero at base; code uses one flag and offset for all entries, from the last accepted start.
// - Substitute flag overwrites message bytes 4..7 with return path.
// - Start count four bytes, used by first data message.
// - Tag is two bytes matching the process tag.
// - Threshold count four bytes triggers further data messages.
// - Unique identifier is eight bytes, same for all configurers.
// - Quiesce aborts related processes then sends response with code.
// - Per-node deadlock flag limits outstanding messages to that node.
// - Finished channel removed; if sole channel, complete and free entry.
// Outstanding transfer table for the target transport layer.
// Assumes one request strobe per cycle; upper layer honours return codes.
`include "tstt_regs.svh"
`default_nettype none
module tstt_table (
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	input wire logic I_CE,
	input wire logic I_START,
	input wire logic I_START_IS_READ,
	input wire logic [`TSTT_TAG_W-1:0] I_START_TAG,
	input wire logic [`TSTT_RPID_W-1:0] I_START_RPID,
	input wire logic [`TSTT_CNT_W-1:0] I_START_COUNT,
	input wire logic [`TSTT_CNT_W-1:0] I_THRESH_COUNT,
	input wire logic [`TSTT_CNT_W-1:0] I_BYTE_OFFSET,
	input wire logic I_IN_ORDER,
	output logic O_START_ACK,
	output logic [7:0] O_START_RC,
	output logic [`TSTT_IDX_W-1:0] O_START_IDX,
	input wire logic I_CH_ADD,
	input wire logic [`TSTT_IDX_W-1:0] I_CH_IDX,
	input wire logic [`TSTT_CH_W-1:0] I_CH_VAL,
	input wire logic I_CH_END,
	input wire logic I_CH_END_FAIL,
	input wire logic [`TSTT_CH_W-1:0] I_CH_END_VAL,
	input wire logic I_XID_ADD,
	input wire logic I_XID_DROP,
	input wire logic [`TSTT_IDX_W-1:0] I_XID_IDX,
	input wire logic [`TSTT_XID_W-1:0] I_XID_VAL,
	input wire logic [`TSTT_CNT_W-1:0] I_AVAIL,
	output logic O_NEXT_MSG,
	input wire logic [`TSTT_CNT_W-1:0] I_DATA_POS,
	output logic [`TSTT_CNT_W-1:0] O_STORE_ADDR,
	output logic O_DONE,
	output logic O_DONE_READ,
	output logic [`TSTT_TAG_W-1:0] O_DONE_TAG,
	output logic [`TSTT_RPID_W-1:0] O_DONE_RPID,
	output logic [7:0] O_DONE_RC,
	input wire logic I_MSG_SUBST,
	input wire logic [63:0] I_MSG_HDR,
	input wire logic [`TSTT_RPID_W-1:0] I_DEST_RPID,
	input wire logic [7:0] I_MSG_CTRL,
	output logic [63:0] O_MSG_HDR,
	output logic [7:0] O_MSG_CTRL,
	input wire logic I_DEADLOCK_FLAG,
	input wire logic I_MSG_SENT,
	input wire logic I_MSG_ANSWERED,
	output logic O_MSG_ALLOW,
	input wire logic I_QUIESCE,
	output logic O_ABORT_ALL,
	input wire logic I_ABORT_DONE,
	input wire logic I_ABORT_FAIL,
	output logic O_RESP_SEND,
	output logic [7:0] O_RESP_RC
);
	logic [`TSTT_DEPTH-1:0] used_r;
	logic [`TSTT_DEPTH-1:0] rd_r;
	logic [`TSTT_NCH-1:0] chv_r [0:`TSTT_DEPTH-1];
	logic [`TSTT_CH_W-1:0] ch_r [0:`TSTT_DEPTH-1][0:`TSTT_NCH-1];
	logic [`TSTT_NXF-1:0] xv_r [0:`TSTT_DEPTH-1];
	logic [`TSTT_XID_W-1:0] xid_r [0:`TSTT_DEPTH-1][0:`TSTT_NXF-1];
	logic [`TSTT_CNT_W-1:0] thr_r [0:`TSTT_DEPTH-1];
	logic [`TSTT_CNT_W-1:0] off_r;
	logic in_order_r;
	logic [`TSTT_IDX_W-1:0] free_idx;
	logic free_ok;
	logic [`TSTT_IDX_W-1:0] hit_idx;
	logic [`TSTT_NCH-1:0] hit_slot;
	logic hit_ok;
	logic [`TSTT_TAG_W+`TSTT_RPID_W-1:0] mem_rdata;
	logic done_pend_r;
	logic done_fail_r;
	logic done_rd_r;
	logic outstanding_r;
	tstt_pkg::tstt_qstate_t q_r;
	logic q_fail_r;
	function automatic logic [`TSTT_IDX_W:0] first_zero(input logic [`TSTT_DEPTH-1:0] v);
		logic [`TSTT_IDX_W:0] r;
		r = '0;
		for (int i = `TSTT_DEPTH - 1; i >= 0; i--) begin
			if (!v[i]) begin
				r = {1'b1, i[`TSTT_IDX_W-1:0]};
			end
		end
		return r;
	endfunction
	always_comb begin
		logic [`TSTT_IDX_W:0] f;
		f = first_zero(used_r);
		free_ok = f[`TSTT_IDX_W];
		free_idx = f[`TSTT_IDX_W-1:0];
	end
	// Channel lookup; first match wins if software duplicated a channel
	always_comb begin
		hit_ok = 1'b0;
		hit_idx = '0;
		hit_slot = '0;
		for (int e = `TSTT_DEPTH - 1; e >= 0; e--) begin
			for (int s = `TSTT_NCH - 1; s >= 0; s--) begin
				if (used_r[e] && chv_r[e][s] && ch_r[e][s] == I_CH_END_VAL) begin
					hit_ok = 1'b1;
					hit_idx = e[`TSTT_IDX_W-1:0];
					hit_slot = '0;
					hit_slot[s] = 1'b1;
				end
			end
		end
	end
	wire logic ch_end_hit = I_CH_END && hit_ok;
	wire logic sole_ch = (chv_r[hit_idx] & ~hit_slot) == '0;
	wire logic finish = ch_end_hit && sole_ch;
	wire logic do_alloc = I_START && free_ok && q_r == tstt_pkg::ST_IDLE;

	// Start answer: failure when full or while quiescing
	always_comb begin
		O_START_ACK = I_START;
		O_START_IDX = free_idx;
		O_START_RC = do_alloc ? `TSTT_RC_OK : `TSTT_RC_FAIL;
	end

	tstt_mem u_mem (
		.i_clk(I_CLK_SYS),
		.i_ce(I_CE),
		.i_we(do_alloc),
		.i_waddr(free_idx),
		.i_wdata({I_START_TAG, I_START_RPID}),
		.i_raddr(hit_idx),
		.o_rdata(mem_rdata)
	);
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			used_r <= '0;
			rd_r <= '0;
		end else if (I_CE) begin
			if (q_r == tstt_pkg::ST_QUI && I_ABORT_DONE) begin
				used_r <= '0;
			end else begin
				if (finish) begin
					used_r[hit_idx] <= 1'b0;
				end
				if (do_alloc) begin
					used_r[free_idx] <= 1'b1;
					rd_r[free_idx] <= I_START_IS_READ;
				end
			end
		end
	end

	generate
		for (genvar e = 0; e < `TSTT_DEPTH; e++) begin : g_ent
			always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
				if (I_RST) begin
					chv_r[e] <= '0;
					xv_r[e] <= '0;
					thr_r[e] <= '0;
				end else if (I_CE) begin
					if (do_alloc && free_idx == e) begin
						chv_r[e] <= '0;
						xv_r[e] <= '0;
						thr_r[e] <= I_THRESH_COUNT;
					end else begin
						if (ch_end_hit && hit_idx == e) begin
							chv_r[e] <= chv_r[e] & ~hit_slot;
						end else if (I_CH_ADD && I_CH_IDX == e && used_r[e]) begin
							for (int s = `TSTT_NCH - 1; s >= 0; s--) begin
								if (!chv_r[e][s] && (chv_r[e] & ((1 << s) - 1)) ==
									((1 << s) - 1)) begin
									chv_r[e][s] <= 1'b1;
									ch_r[e][s] <= I_CH_VAL;
								end
							end
						end
						if (I_XID_IDX == e && used_r[e] && rd_r[e]) begin
							for (int s = 0; s < `TSTT_NXF; s++) begin
								if (I_XID_DROP && xv_r[e][s] && xid_r[e][s] == I_XID_VAL) begin
									xv_r[e][s] <= 1'b0;
								end
							end
							if (I_XID_ADD && !I_XID_DROP) begin
								for (int s = `TSTT_NXF - 1; s >= 0; s--) begin
									if (!xv_r[e][s] && (xv_r[e] & ((1 << s) - 1)) ==
										((1 << s) - 1)) begin
										xv_r[e][s] <= 1'b1;
										xid_r[e][s] <= I_XID_VAL;
									end
								end
							end
						end
					end
				end
			end
		end
	endgenerate
	a_xid_add: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(I_CE && I_XID_ADD && !I_XID_DROP && used_r[I_XID_IDX] && rd_r[I_XID_IDX]
		&& !xv_r[I_XID_IDX][0]) |=> xv_r[$past(I_XID_IDX)][0])
		else $error("transfer id not recorded");
	a_xid_drop: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(I_CE && I_XID_DROP && used_r[I_XID_IDX] && rd_r[I_XID_IDX] && xv_r[I_XID_IDX][0]
		&& xid_r[I_XID_IDX][0] == I_XID_VAL) |=> !xv_r[$past(I_XID_IDX)][0])
		else $error("transfer id not dropped");
	// Threshold reached on the addressed entry asks for the next data message
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			O_NEXT_MSG <= 1'b0;
		end else if (I_CE) begin
			O_NEXT_MSG <= used_r[I_XID_IDX] && I_AVAIL >= thr_r[I_XID_IDX];
		end
	end

	// Placement base latched at start; out-of-order mode ignores the placement base
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			off_r <= '0;
			in_order_r <= 1'b0;
			O_STORE_ADDR <= '0;
		end else if (I_CE) begin
			if (do_alloc) begin
				off_r <= I_BYTE_OFFSET;
				in_order_r <= I_IN_ORDER;
			end
			O_STORE_ADDR <= in_order_r ? I_DATA_POS - off_r : I_DATA_POS;
		end
	end

	// Completion is two cycles after the end, since table read data is registered
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			done_pend_r <= 1'b0;
			done_fail_r <= 1'b0;
			done_rd_r <= 1'b0;
		end else if (I_CE) begin
			done_pend_r <= finish;
			done_fail_r <= I_CH_END_FAIL;
			done_rd_r <= rd_r[hit_idx];
		end
	end

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			O_DONE <= 1'b0;
			O_DONE_READ <= 1'b0;
			O_DONE_TAG <= '0;
			O_DONE_RPID <= '0;
			O_DONE_RC <= `TSTT_RC_OK;
		end else if (I_CE) begin
			O_DONE <= done_pend_r;
			if (done_pend_r) begin
				O_DONE_READ <= done_rd_r;
				O_DONE_TAG <= mem_rdata[`TSTT_TAG_W+`TSTT_RPID_W-1:`TSTT_RPID_W];
				O_DONE_RPID <= mem_rdata[`TSTT_RPID_W-1:0];
				O_DONE_RC <= done_fail_r ? `TSTT_RC_FAIL : `TSTT_RC_OK;
			end
		end
	end

	// Outgoing message header: bytes 4..7 replaced by return path
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			O_MSG_HDR <= '0;
			O_MSG_CTRL <= '0;
		end else if (I_CE) begin
			O_MSG_HDR <= I_MSG_SUBST ? {I_MSG_HDR[63:`TSTT_RPID_LO], I_DEST_RPID}
				: I_MSG_HDR;
			O_MSG_CTRL <= I_MSG_CTRL & ~`TSTT_CTRL_FSN_MASK;
		end
	end

	// Deadlock flag: one outstanding message at a time to that node
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			outstanding_r <= 1'b0;
		end else if (I_CE) begin
			if (I_MSG_SENT) begin
				outstanding_r <= 1'b1;
			end else if (I_MSG_ANSWERED) begin
				outstanding_r <= 1'b0;
			end
		end
	end
	assign O_MSG_ALLOW = !I_DEADLOCK_FLAG || !outstanding_r;
	// Quiesce sequencer
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			q_r <= tstt_pkg::ST_IDLE;
			q_fail_r <= 1'b0;
		end else if (I_CE) begin
			case (q_r)
				tstt_pkg::ST_IDLE: begin
					if (I_QUIESCE) begin
						q_r <= tstt_pkg::ST_QUI;
					end
				end
				tstt_pkg::ST_QUI: begin
					if (I_ABORT_DONE) begin
						q_fail_r <= I_ABORT_FAIL;
						q_r <= tstt_pkg::ST_RESP;
					end
				end
				tstt_pkg::ST_RESP: begin
					q_r <= tstt_pkg::ST_IDLE;
				end
				default: begin
					q_r <= tstt_pkg::ST_IDLE;
				end
			endcase
		end
	end
	assign O_ABORT_ALL = q_r == tstt_pkg::ST_QUI;
	assign O_RESP_SEND = q_r == tstt_pkg::ST_RESP;
	assign O_RESP_RC = q_fail_r ? `TSTT_RC_FAIL : `TSTT_RC_OK;
	a_done_after_finish: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(finish && I_CE) ##1 I_CE |=> O_DONE)
		else $error("completion missing after sole channel end");
	a_alloc_sets_used: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(do_alloc && I_CE) |=> used_r[$past(free_idx)])
		else $error("start did not allocate entry");
	a_free_after_done: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(finish && I_CE && !do_alloc && q_r == tstt_pkg::ST_IDLE) |=> !used_r[$past(hit_idx)])
		else $error("entry not freed");
	a_full_fails: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(I_START && !free_ok) |-> O_START_RC == `TSTT_RC_FAIL)
		else $error("full table accepted start");
	a_subst_bytes: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(I_CE && I_MSG_SUBST) |=> O_MSG_HDR[31:0] == $past(I_DEST_RPID))
		else $error("return path not substituted");
	a_fsn_zero: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(O_MSG_CTRL & `TSTT_CTRL_FSN_MASK) == 8'h00)
		else $error("sequence number field not zero");
	sequence s_quiesce;
		q_r == tstt_pkg::ST_QUI ##1 (I_CE && I_ABORT_DONE && q_r == tstt_pkg::ST_QUI);
	endsequence
	a_quiesce_resp: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		s_quiesce |=> O_RESP_SEND && used_r == '0)
		else $error("quiesce response missing");
	a_deadlock_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(I_DEADLOCK_FLAG && outstanding_r) |-> !O_MSG_ALLOW)
		else $error("deadlock limit broken");
	a_partial_end: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(I_CE && ch_end_hit && !sole_ch) |=> !O_DONE ##1 !O_DONE)
		else $error("completion on partial end");
endmodule
`default_nettype wire

// file: test/tstt_upper_model.sv
// Upper protocol layer model answering the abort request of a quiesce.
// Assumes the table raises its abort level and holds it until the done pulse.
`default_nettype none
module tstt_upper_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_abort_all,
	input wire logic [3:0] i_lat,
	input wire logic i_fail,
	output logic o_abort_done,
	output logic o_abort_fail
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r;

	// Fail flag flips when not qualified, so a stale level is never trusted
	always_ff @(negedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r <= 4'h0;
			o_abort_done <= 1'b0;
			o_abort_fail <= 1'b0;
		end else if (i_abort_all && !o_abort_done) begin
			if (cnt_r == i_lat) begin
				o_abort_done <= 1'b1;
				o_abort_fail <= i_fail;
				cnt_r <= 4'h0;
			end else begin
				cnt_r <= cnt_r + 4'h1;
				o_abort_fail <= ~o_abort_fail;
			end
		end else begin
			o_abort_done <= 1'b0;
			o_abort_fail <= ~o_abort_fail;
			cnt_r <= 4'h0;
		end
	end
endmodule
`default_nettype wire

// file: test/tstt_table_tb.sv
// Self-checking bench for the outstanding transfer table.
// Assumes the design headers on the include path and the upper layer model.
`default_nettype none
module tstt_table_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, start = 0, s_rd = 0, in_ord = 0, ch_add = 0, ch_end = 0;
	logic ch_fail = 0, xadd = 0, xdrop = 0, subst = 0, dlk = 0, sent = 0, answ = 0, qui = 0;
	logic p_fail = 0, ce = 1;
	logic ack, nxt, done, d_rd, allow, ab_all, ab_done, ab_fail, resp;
	logic [1:0] ch_ix = 0, x_ix = 0, s_ix;
	logic [1:0] eix [4];
	logic [3:0] p_lat = 0;
	logic [7:0] x_val = 0, m_ctl = 0, s_rc, d_rc, r_rc, o_ctl;
	logic [15:0] s_tag = 0, ch_v = 0, ch_ev = 0, d_tag;
	logic [31:0] s_rp = 0, s_cnt = 32'h0000_0040, thr = 32'h0000_0100, offs = 0;
	logic [31:0] avail = 0, dpos = 0, dst_rp = 0, d_rp, st_addr;
	logic [63:0] m_hdr = 0, o_hdr;
	logic [1:0] ix;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;

	tstt_table dut_u (.I_CLK_SYS(clk), .I_RST(rst), .I_CE(ce), .I_START(start),
		.I_START_IS_READ(s_rd), .I_START_TAG(s_tag), .I_START_RPID(s_rp), .I_START_COUNT(s_cnt),
		.I_THRESH_COUNT(thr), .I_BYTE_OFFSET(offs), .I_IN_ORDER(in_ord), .O_START_ACK(ack),
		.O_START_RC(s_rc), .O_START_IDX(s_ix), .I_CH_ADD(ch_add), .I_CH_IDX(ch_ix), .I_CH_VAL(ch_v),
		.I_CH_END(ch_end), .I_CH_END_FAIL(ch_fail), .I_CH_END_VAL(ch_ev), .I_XID_ADD(xadd),
		.I_XID_DROP(xdrop), .I_XID_IDX(x_ix), .I_XID_VAL(x_val), .I_AVAIL(avail), .O_NEXT_MSG(nxt),
		.I_DATA_POS(dpos), .O_STORE_ADDR(st_addr), .O_DONE(done), .O_DONE_READ(d_rd),
		.O_DONE_TAG(d_tag), .O_DONE_RPID(d_rp), .O_DONE_RC(d_rc), .I_MSG_SUBST(subst),
		.I_MSG_HDR(m_hdr), .I_DEST_RPID(dst_rp), .I_MSG_CTRL(m_ctl), .O_MSG_HDR(o_hdr),
		.O_MSG_CTRL(o_ctl), .I_DEADLOCK_FLAG(dlk), .I_MSG_SENT(sent), .I_MSG_ANSWERED(answ),
		.O_MSG_ALLOW(allow), .I_QUIESCE(qui), .O_ABORT_ALL(ab_all), .I_ABORT_DONE(ab_done),
		.I_ABORT_FAIL(ab_fail), .O_RESP_SEND(resp), .O_RESP_RC(r_rc));

	tstt_upper_model peer_u (.i_clk(clk), .i_rst(rst), .i_abort_all(ab_all), .i_lat(p_lat),
		.i_fail(p_fail), .o_abort_done(ab_done), .o_abort_fail(ab_fail));

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Hang guard: the whole sequence needs under a hundred cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			error_cnt++;
			give_verdict();
		end
	end

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic idle();
		@(negedge clk);
		start = 1'b0;
		ch_add = 1'b0;
		ch_end = 1'b0;
		xadd = 1'b0;
		xdrop = 1'b0;
		sent = 1'b0;
		answ = 1'b0;
		qui = 1'b0;
	endtask

	// Leaves the request up so calls can run back to back
	task automatic do_start(input logic [15:0] tg, input logic io, input logic [7:0] rc,
		output logic [1:0] idx);
		@(negedge clk);
		start = 1'b1;
		s_rd = ~io;
		s_tag = tg;
		s_rp = {16'hC0DE, tg};
		in_ord = io;
		offs = 32'h0000_0100 + {28'h000_0000, tg[3:0]};
		#1;
		chk("start_ack", ack, 1'b1);
		chk("start_rc", s_rc, rc);
		idx = s_ix;
	endtask

	task automatic fill(input logic [7:0] tb);
		logic [1:0] dummy;
		for (int e = 0; e < 4; e++) do_start({tb, 8'(e)}, e[0], 8'h00, eix[e]);
		do_start({tb, 8'h09}, 1'b0, 8'hFE, dummy);
		idle();
	endtask

	task automatic chan(input logic add, input logic [1:0] cx, input logic [15:0] v,
		input logic fl);
		@(negedge clk);
		ch_add = add;
		ch_end = ~add;
		ch_ix = cx;
		ch_v = v;
		ch_ev = v;
		ch_fail = fl;
		idle();
	endtask

	task automatic exp_done(input logic want, input logic [15:0] tg, input logic [7:0] rc,
		input logic rd);
		logic seen;
		seen = 1'b0;
		for (int n = 0; n < 5; n++) begin
			if (done === 1'b1) begin
				seen = 1'b1;
				chk("done_tag", d_tag, tg);
				chk("done_rpid", d_rp, {16'hC0DE, tg});
				chk("done_rc", d_rc, rc);
				chk("done_read", d_rd, rd);
			end
			@(negedge clk);
		end
		chk("done_seen", seen, want);
	endtask

	task automatic quiesce(input logic fl, input logic [7:0] rc);
		logic [1:0] qx;
		p_fail = fl;
		p_lat = 4'h3;
		@(negedge clk);
		qui = 1'b1;
		idle();
		chk("abort_all", ab_all, 1'b1);
		do_start(16'hEEEE, 1'b0, 8'hFE, qx);
		idle();
		for (int n = 0; n < 20 && resp !== 1'b1; n++) @(negedge clk);
		chk("resp", resp, 1'b1);
		chk("resp_rc", r_rc, rc);
	endtask

	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		chk("rst_allow", allow, 1'b1);
		chk("rst_done", done, 1'b0);
		fill(8'hA0);
		for (int e = 2; e < 4; e++) begin
			@(negedge clk);
			x_ix = eix[e];
			xadd = 1'b1;
			x_val = 8'(e);
			avail = thr - 32'h0000_0001;
			dpos = 32'h0000_1000;
			@(negedge clk);
			xadd = 1'b0;
			chk("next_low", nxt, 1'b0);
			// One placement base for the table: last accepted start was in-order, offset 103h
			chk("store", st_addr, dpos - 32'h0000_0103);
			avail = thr;
			@(negedge clk);
			chk("next_high", nxt, 1'b1);
		end
		@(negedge clk);
		x_ix = eix[2];
		xdrop = 1'b1;
		x_val = 8'h02;
		idle();
		chan(1'b1, eix[0], 16'h0100, 1'b0);
		chan(1'b1, eix[0], 16'h0200, 1'b0);
		chan(1'b1, eix[1], 16'h0101, 1'b0);
		chan(1'b0, 2'h0, 16'h0200, 1'b0);
		exp_done(1'b0, 16'hA000, 8'h00, 1'b1);
		chan(1'b0, 2'h0, 16'h7777, 1'b0);
		exp_done(1'b0, 16'hA000, 8'h00, 1'b1);
		chan(1'b0, 2'h0, 16'h0100, 1'b0);
		exp_done(1'b1, 16'hA000, 8'h00, 1'b1);
		do_start(16'hB000, 1'b0, 8'h00, ix);
		idle();
		chk("reuse_idx", ix, eix[0]);
		chan(1'b0, 2'h0, 16'h0101, 1'b1);
		chk("store_raw", st_addr, 32'h0000_1000);
		exp_done(1'b1, 16'hA001, 8'hFE, 1'b0);
		@(negedge clk);
		subst = 1'b1;
		m_hdr = 64'h1122_3344_5566_7788;
		dst_rp = 32'hA5A5_5A5A;
		m_ctl = 8'hFF;
		@(negedge clk);
		chk("hdr_sub", o_hdr, 64'h1122_3344_A5A5_5A5A);
		chk("ctrl", o_ctl, 8'h0F);
		subst = 1'b0;
		dlk = 1'b1;
		@(negedge clk);
		chk("hdr_keep", o_hdr, m_hdr);
		sent = 1'b1;
		idle();
		chk("allow_held", allow, 1'b0);
		ce = 1'b0;
		answ = 1'b1;
		@(negedge clk);
		chk("ce_freeze", allow, 1'b0);
		ce = 1'b1;
		@(negedge clk);
		answ = 1'b1;
		idle();
		chk("allow_back", allow, 1'b1);
		quiesce(1'b0, 8'h00);
		fill(8'hC0);
		quiesce(1'b1, 8'hFE);
		give_verdict();
	end
endmodule
`default_nettype wire
